// File: hw/roceb_defs.svh
/*
  Constants of the receive output clocking and elasticity buffer block.
  Assumes it is included by bare name from files that need these numbers.
*/
// What this block does
// RQ1: decoder bypass passes each raw 10-bit character unchanged to the output register.
// RQ2: configuring party keeps receive clock select at MID whenever decoder is bypassed.
// RQ3: decoder mode MID uses the primary special table, HIGH the alternate.
// RQ4: receive clock select LOW clocks output from reference, output clocks copy it.
// RQ5: receive clock select MID follows recovered clock at chosen rate, buffer bypassed.
// RQ6: configuring party never drives receive clock select HIGH.
// RQ7: serial rate select gives 195-400, 400-800 or 800-1500 MBaud ranges.
// RQ8: half-rate transmit reference is not chosen while serial rate select is LOW.
// RQ9: transmit clock select LOW captures transmit data on the reference clock.
// RQ10: clock select LOW with decoder on enables buffer, output timed by reference.
// RQ11: frequency offset absorbed only by inserting or deleting framing characters.
// RQ12: an added character is one K28.5 right after a detected framing character.
// RQ13: a dropped character is a framing character removed where it is detected.
// RQ14: active-low reset initializes every state machine and counter.
// RQ15: reset sampled on reference edge; while low, buffer pointers take nominal offset.
// RQ16: outputs become deterministic within fewer than 16 reference cycles after release.
// RQ17: framing is either comma polarity at MID, either K28.5 polarity at HIGH.
// RQ18: buffer depth and fill thresholds keep the buffer near half full.
`ifndef ROCEB_DEFS_SVH
`define ROCEB_DEFS_SVH

// register byte offsets
`define ROCEB_REG_CONFIG 4'h0
`define ROCEB_REG_STATUS 4'h4
`define ROCEB_REG_COUNT 4'h8
`define ROCEB_REG_RANGE 4'hC

// configuration reset: every select floats to MID
`define ROCEB_CFG_RESET 14'h1555

// status, count and range field positions
`define ROCEB_ST_EBACTIVE_POS 0
`define ROCEB_ST_CFGBAD_POS 1
`define ROCEB_ST_TXREF_POS 2
`define ROCEB_ST_OVERFLOW_POS 3
`define ROCEB_ST_UNDERFLOW_POS 4
`define ROCEB_ST_FILL_POS 8
`define ROCEB_CNT_DELETE_POS 16
`define ROCEB_RANGE_MAX_POS 16

// elasticity buffer sizing
`define ROCEB_EB_DEPTH 16
`define ROCEB_EB_LO_TH 6
`define ROCEB_EB_HI_TH 10

// character codes
`define ROCEB_K285_NEG 10'h0FA
`define ROCEB_K285_POS 10'h305
`define ROCEB_COMMA_NEG 7'h1F
`define ROCEB_COMMA_POS 7'h60
`define ROCEB_K285_BYTE 8'hBC

// serial rate ranges in MBaud
`define ROCEB_RANGE_LOW_MIN 16'd195
`define ROCEB_RANGE_LOW_MAX 16'd400
`define ROCEB_RANGE_MID_MAX 16'd800
`define ROCEB_RANGE_HIGH_MAX 16'd1500

`endif

// File: hw/roceb_pkg.sv
/*
  Types of the receive output clocking and elasticity buffer block.
  Assumes no other package.
*/
package roceb_pkg;
  typedef enum logic [1:0] {TRI_LOW, TRI_MID, TRI_HIGH, TRI_RSVD} roceb_tri_e;
  typedef enum logic [2:0] {
    RXST_DATA, RXST_SPECIAL, RXST_COMMA, RXST_ERROR, RXST_RAW, RXST_FILL
  } roceb_rxst_e;
  typedef enum logic {RD_PASS, RD_INSERT} roceb_rdst_e;
  typedef struct packed {
    logic [9:0] data;
    roceb_rxst_e status;
  } roceb_rxword_s;
  typedef struct packed {
    roceb_tri_e framSel;
    roceb_tri_e txClkSel;
    roceb_tri_e tx_ref_rate_select;
    roceb_tri_e serial_rate_range_select;
    roceb_tri_e rx_recovered_rate_select;
    roceb_tri_e rxClkSel;
    roceb_tri_e decoder_mode_select;
  } roceb_cfg_s;
endpackage

// File: hw/roceb_mem.sv
/*
  Two-port character memory of the elasticity buffer, registered read data.
  Assumes one clock and write and read addresses in range.
*/
`timescale 1ns/10ps
module roceb_mem #(
  parameter int W = 10,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input wire logic [W-1:0] wrData,
  input wire logic rdEn,
  input wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic [W-1:0] rdData
);
  logic [W-1:0] store [DEPTH];

  // storage has no reset; the reader primes over slots never written
  always_ff @(posedge clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  // read data comes out of a register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdData <= '0;
    end else if (rdEn) begin
      rdData <= store[rdAddr];
    end
  end
endmodule

// File: hw/roceb_top.sv
/*
  Receive output path: decoder select, output clock select, elasticity buffer,
  and an AXI4-Lite slave holding configuration and status.
  Assumes clk is the reference clock and received characters arrive synchronous
  to it, one per rxCharValid pulse standing for a recovered clock edge.
*/
`timescale 1ns/10ps
`include "roceb_defs.svh"
module roceb_top
  import roceb_pkg::*;
#(
  parameter int DEPTH = `ROCEB_EB_DEPTH,
  parameter int LO_TH = `ROCEB_EB_LO_TH,
  parameter int HI_TH = `ROCEB_EB_HI_TH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [9:0] rxCharIn,
  input wire logic rxCharValid,
  output roceb_rxword_s rxOutWord,
  output logic rxOutValid,
  output logic rxOutClk,
  output logic rxOutClkCopy,
  output logic txRefCapture,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] HALF = (PW+1)'(DEPTH / 2);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  localparam logic [PW:0] LO = (PW+1)'(LO_TH);
  localparam logic [PW:0] HI = (PW+1)'(HI_TH);

  // 6b sub-block to {valid, 5-bit value}
  function automatic logic [5:0] dec6(input logic [5:0] s);
    case (s)
      6'h27, 6'h18: dec6 = 6'h20;
      6'h1D, 6'h22: dec6 = 6'h21;
      6'h2D, 6'h12: dec6 = 6'h22;
      6'h31: dec6 = 6'h23;
      6'h35, 6'h0A: dec6 = 6'h24;
      6'h29: dec6 = 6'h25;
      6'h19: dec6 = 6'h26;
      6'h38, 6'h07: dec6 = 6'h27;
      6'h39, 6'h06: dec6 = 6'h28;
      6'h25: dec6 = 6'h29;
      6'h15: dec6 = 6'h2A;
      6'h34: dec6 = 6'h2B;
      6'h0D: dec6 = 6'h2C;
      6'h2C: dec6 = 6'h2D;
      6'h1C: dec6 = 6'h2E;
      6'h17, 6'h28: dec6 = 6'h2F;
      6'h1B, 6'h24: dec6 = 6'h30;
      6'h23: dec6 = 6'h31;
      6'h13: dec6 = 6'h32;
      6'h32: dec6 = 6'h33;
      6'h0B: dec6 = 6'h34;
      6'h2A: dec6 = 6'h35;
      6'h1A: dec6 = 6'h36;
      6'h3A, 6'h05: dec6 = 6'h37;
      6'h33, 6'h0C: dec6 = 6'h38;
      6'h26: dec6 = 6'h39;
      6'h16: dec6 = 6'h3A;
      6'h36, 6'h09: dec6 = 6'h3B;
      6'h0E, 6'h0F, 6'h30: dec6 = 6'h3C;
      6'h2E, 6'h11: dec6 = 6'h3D;
      6'h1E, 6'h21: dec6 = 6'h3E;
      6'h2B, 6'h14: dec6 = 6'h3F;
      default: dec6 = 6'h00;
    endcase
  endfunction

  // 4b sub-block to {valid, 3-bit value}
  function automatic logic [3:0] dec4(input logic [3:0] s);
    case (s)
      4'hB, 4'h4: dec4 = 4'h8;
      4'h9: dec4 = 4'h9;
      4'h5: dec4 = 4'hA;
      4'hC, 4'h3: dec4 = 4'hB;
      4'hD, 4'h2: dec4 = 4'hC;
      4'hA: dec4 = 4'hD;
      4'h6: dec4 = 4'hE;
      4'hE, 4'h1, 4'h7, 4'h8: dec4 = 4'hF;
      default: dec4 = 4'h0;
    endcase
  endfunction

  // one character through the decoder or around it
  function automatic roceb_rxword_s decodeChar(input logic [9:0] c, input roceb_tri_e mode);
    logic [5:0] d6;
    logic [3:0] d4;
    logic isK;
    logic isK285;
    roceb_rxword_s w;
    d6 = dec6(c[9:4]);
    d4 = dec4((c[9:4] == 6'h30) ? ~c[3:0] : c[3:0]); // K28 positive flips the 4b
    isK285 = (c == `ROCEB_K285_NEG) || (c == `ROCEB_K285_POS);
    isK = (c[9:4] == 6'h0F) || (c[9:4] == 6'h30) ||
          ((c[3:0] == 4'h7 || c[3:0] == 4'h8) &&
           (d6[4:0] == 5'd23 || d6[4:0] == 5'd27 || d6[4:0] == 5'd29 || d6[4:0] == 5'd30));
    w.data = {2'h0, d4[2:0], d6[4:0]};
    if (mode == TRI_LOW) begin
      w.data = c; // RQ1
      w.status = RXST_RAW;
    end else if (!d6[5] || !d4[3]) begin
      w.status = RXST_ERROR;
    end else if (isK) begin
      // primary table tags K28.5 as comma, alternate lumps all specials
      w.status = (mode == TRI_MID && isK285) ? RXST_COMMA : RXST_SPECIAL; // RQ3
    end else begin
      w.status = RXST_DATA;
    end
    return w;
  endfunction

  // framing character match for the selected framing kind
  function automatic logic isFraming(input logic [9:0] c, input roceb_tri_e sel);
    if (sel == TRI_HIGH) begin
      return (c == `ROCEB_K285_NEG) || (c == `ROCEB_K285_POS); // RQ17
    end
    return (c[9:3] == `ROCEB_COMMA_NEG) || (c[9:3] == `ROCEB_COMMA_POS); // RQ17
  endfunction

  // low and high ends of the PLL range in MBaud
  function automatic logic [31:0] rangeOf(input roceb_tri_e sel);
    case (sel)
      TRI_LOW: rangeOf = {`ROCEB_RANGE_LOW_MAX, `ROCEB_RANGE_LOW_MIN};
      TRI_MID: rangeOf = {`ROCEB_RANGE_MID_MAX, `ROCEB_RANGE_LOW_MAX};
      default: rangeOf = {`ROCEB_RANGE_HIGH_MAX, `ROCEB_RANGE_MID_MAX};
    endcase
  endfunction

  roceb_cfg_s cfg_reg;
  roceb_rdst_e rdState_reg;
  logic [PW:0] wrPtr_reg, rdPtr_reg, primeCnt_reg;
  logic rdValid_reg, rdPrime_reg, halfDiv_reg, overflow_reg, underflow_reg;
  logic [15:0] insertCnt_reg, deleteCnt_reg;
  logic [31:0] range_reg;
  logic [9:0] memData;
  logic [3:0] awAddr_reg, arAddr;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;

  // mode decode
  wire decOn = cfg_reg.decoder_mode_select != TRI_LOW;
  wire ebActive = (cfg_reg.rxClkSel == TRI_LOW) && decOn; // RQ10
  wire cfgBad = (!decOn && cfg_reg.rxClkSel != TRI_MID) || (cfg_reg.rxClkSel == TRI_HIGH) ||
                (cfg_reg.serial_rate_range_select == TRI_LOW && cfg_reg.tx_ref_rate_select == TRI_HIGH);
  wire [PW:0] fill = wrPtr_reg - rdPtr_reg;
  wire inFraming = rxCharValid && isFraming(rxCharIn, cfg_reg.framSel);
  wire dropChar = ebActive && inFraming && (fill >= HI); // RQ13 RQ18
  wire wrEn = ebActive && rxCharValid && !dropChar && (fill != FULL); // RQ5
  wire overflowNow = ebActive && rxCharValid && !dropChar && (fill == FULL);
  wire insertNow = ebActive && rdValid_reg && !rdPrime_reg &&
                   isFraming(memData, cfg_reg.framSel) && (fill < LO); // RQ12 RQ18
  wire rdEn = ebActive && !insertNow && (fill != '0); // RQ11
  wire underflowNow = ebActive && rdState_reg == RD_PASS && !rdValid_reg;
  // inserted cycle and priming both present known characters
  wire [9:0] srcChar = !ebActive ? rxCharIn :
                       (rdState_reg == RD_INSERT) ? `ROCEB_K285_NEG : memData; // RQ12
  wire srcFill = underflowNow || (rdState_reg == RD_PASS && rdPrime_reg);
  wire roceb_rxword_s decWord = decodeChar(srcChar, cfg_reg.decoder_mode_select);
  wire loadOut = ebActive || rxCharValid; // RQ4 RQ5

  roceb_mem #(.W(10), .DEPTH(DEPTH)) u_mem (
    .clk(clk),
    .nrst(nrst),
    .wrEn(wrEn),
    .wrAddr(wrPtr_reg[PW-1:0]),
    .wrData(rxCharIn),
    .rdEn(rdEn),
    .rdAddr(rdPtr_reg[PW-1:0]),
    .rdData(memData)
  );

  // buffer pointers: reset parks the writer half a buffer ahead
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrPtr_reg <= HALF; // RQ15
      rdPtr_reg <= '0; // RQ15
      primeCnt_reg <= HALF;
      rdValid_reg <= 1'b0;
      rdPrime_reg <= 1'b0;
      rdState_reg <= RD_PASS; // RQ14
    end else begin
      wrPtr_reg <= wrPtr_reg + (PW+1)'(wrEn);
      rdPtr_reg <= rdPtr_reg + (PW+1)'(rdEn);
      primeCnt_reg <= (rdEn && primeCnt_reg != '0) ? primeCnt_reg - (PW+1)'(1) : primeCnt_reg;
      rdValid_reg <= rdEn;
      rdPrime_reg <= rdEn && (primeCnt_reg != '0);
      rdState_reg <= insertNow ? RD_INSERT : RD_PASS;
    end
  end

  // output register and output clock copies
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxOutWord <= '{data: '0, status: RXST_FILL}; // RQ16
      rxOutValid <= 1'b0;
      rxOutClk <= 1'b0;
      rxOutClkCopy <= 1'b0;
      halfDiv_reg <= 1'b0;
    end else begin
      rxOutValid <= loadOut;
      if (loadOut) begin
        rxOutWord <= (ebActive && srcFill) ? '{data: '0, status: RXST_FILL} : decWord;
      end
      if (ebActive || cfg_reg.rxClkSel == TRI_LOW) begin
        rxOutClk <= ~rxOutClk; // RQ4
        rxOutClkCopy <= ~rxOutClk; // RQ4 realigns after a spell in recovered mode
      end else if (rxCharValid) begin
        // half rate divides recovered character clock by two
        halfDiv_reg <= ~halfDiv_reg;
        if (cfg_reg.rx_recovered_rate_select == TRI_LOW || halfDiv_reg) begin
          rxOutClk <= ~rxOutClk; // RQ5
        end
      end
    end
  end

  // status counters; they wrap, software takes differences
  always_ff @(posedge clk) begin
    if (!nrst) begin
      insertCnt_reg <= '0; // RQ14
      deleteCnt_reg <= '0; // RQ14
      overflow_reg <= 1'b0;
      underflow_reg <= 1'b0;
      txRefCapture <= 1'b0;
      range_reg <= '0;
    end else begin
      insertCnt_reg <= insertCnt_reg + 16'(insertNow);
      deleteCnt_reg <= deleteCnt_reg + 16'(dropChar);
      overflow_reg <= overflowNow;
      underflow_reg <= underflowNow;
      txRefCapture <= cfg_reg.txClkSel == TRI_LOW; // RQ9
      range_reg <= rangeOf(cfg_reg.serial_rate_range_select); // RQ7
    end
  end

  // register read mux
  wire [31:0] statusWord = (32'(ebActive) << `ROCEB_ST_EBACTIVE_POS) |
                           (32'(cfgBad) << `ROCEB_ST_CFGBAD_POS) |
                           (32'(txRefCapture) << `ROCEB_ST_TXREF_POS) |
                           (32'(overflow_reg) << `ROCEB_ST_OVERFLOW_POS) |
                           (32'(underflow_reg) << `ROCEB_ST_UNDERFLOW_POS) |
                           (32'(fill) << `ROCEB_ST_FILL_POS);
  wire [31:0] countWord = {deleteCnt_reg, insertCnt_reg};
  assign arAddr = s_axi_araddr;
  wire arMapped = (arAddr == `ROCEB_REG_CONFIG) || (arAddr == `ROCEB_REG_STATUS) ||
                  (arAddr == `ROCEB_REG_COUNT) || (arAddr == `ROCEB_REG_RANGE);
  wire [31:0] rdWord = (arAddr == `ROCEB_REG_CONFIG) ? {18'h0, cfg_reg} :
                       (arAddr == `ROCEB_REG_STATUS) ? statusWord :
                       (arAddr == `ROCEB_REG_COUNT) ? countWord :
                       (arAddr == `ROCEB_REG_RANGE) ? range_reg : 32'h0;
  // write side: address and data each latched once, then one response
  wire doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire awMapped = (awAddr_reg == `ROCEB_REG_CONFIG) || (awAddr_reg == `ROCEB_REG_STATUS) ||
                  (awAddr_reg == `ROCEB_REG_COUNT) || (awAddr_reg == `ROCEB_REG_RANGE);
  wire [13:0] cfgMerged = {wStrb_reg[1] ? wData_reg[13:8] : cfg_reg[13:8],
                           wStrb_reg[0] ? wData_reg[7:0] : cfg_reg[7:0]};

  // write channel handling
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
      cfg_reg <= roceb_cfg_s'(`ROCEB_CFG_RESET);
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= awMapped ? 2'h0 : 2'h2;
        if (awAddr_reg == `ROCEB_REG_CONFIG) begin
          cfg_reg <= roceb_cfg_s'(cfgMerged);
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel handling; data frozen at the address handshake
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdWord;
      s_axi_rresp <= arMapped ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  AST_BYPASS_RAW: assert property (@(posedge clk) disable iff (!nrst) // RQ1
    (!decOn && rxCharValid) ##1 !decOn |-> rxOutWord.data == $past(rxCharIn)
    && rxOutWord.status == RXST_RAW)
    else $error("bypassed character not passed raw");
  AST_PRIMARY_TABLE: assert property (@(posedge clk) disable iff (!nrst) // RQ3
    (!ebActive && rxCharValid && cfg_reg.decoder_mode_select == TRI_MID &&
     (rxCharIn == `ROCEB_K285_POS || rxCharIn == `ROCEB_K285_NEG))
    |=> rxOutWord.status == RXST_COMMA || $past(cfg_reg) != cfg_reg)
    else $error("primary table did not mark K28.5 as comma");
  AST_ALT_TABLE: assert property (@(posedge clk) disable iff (!nrst) // RQ3
    (!ebActive && rxCharValid && cfg_reg.decoder_mode_select == TRI_HIGH &&
     (rxCharIn == `ROCEB_K285_POS || rxCharIn == `ROCEB_K285_NEG))
    |=> rxOutWord.status == RXST_SPECIAL || $past(cfg_reg) != cfg_reg)
    else $error("alternate table did not mark K28.5 as special");
  AST_REF_CLOCK: assert property (@(posedge clk) disable iff (!nrst) // RQ4
    ebActive ##1 ebActive |-> rxOutClk != $past(rxOutClk) && rxOutClkCopy == rxOutClk)
    else $error("output clock does not follow reference");
  AST_EB_BYPASS: assert property (@(posedge clk) disable iff (!nrst) // RQ5
    !ebActive ##1 !ebActive |-> $stable(wrPtr_reg) && !rdValid_reg)
    else $error("buffer moved while bypassed");
  AST_RANGE: assert property (@(posedge clk) disable iff (!nrst) // RQ7
    cfg_reg.serial_rate_range_select == TRI_HIGH ##1 cfg_reg.serial_rate_range_select == TRI_HIGH |->
    range_reg == {16'd1500, 16'd800})
    else $error("high range not 800 to 1500");
  AST_TX_CAPTURE: assert property (@(posedge clk) disable iff (!nrst) // RQ9
    ##1 txRefCapture == ($past(cfg_reg.txClkSel) == TRI_LOW))
    else $error("transmit capture select wrong");
  AST_EB_LOAD: assert property (@(posedge clk) disable iff (!nrst) // RQ10
    ebActive |=> rxOutValid)
    else $error("output not loaded every reference cycle");
  AST_INSERT: assert property (@(posedge clk) disable iff (!nrst) // RQ12
    insertNow ##1 ebActive |=> rxOutWord.data == {2'h0, `ROCEB_K285_BYTE})
    else $error("inserted character is not K28.5");
  AST_DELETE: assert property (@(posedge clk) disable iff (!nrst) // RQ13
    dropChar |=> wrPtr_reg == $past(wrPtr_reg) && deleteCnt_reg == $past(deleteCnt_reg) + 16'h1)
    else $error("framing character not dropped");
  AST_RESET_PTR: assert property (@(posedge clk) // RQ15
    !nrst |=> wrPtr_reg == HALF && rdPtr_reg == '0 && !rxOutValid)
    else $error("reset did not set nominal offset");
  AST_FILL_BOUND: assert property (@(posedge clk) disable iff (!nrst) // RQ11
    fill <= FULL)
    else $error("buffer fill out of bounds");
endmodule

// File: verification/roceb_host_model.sv
/*
  Host logic that takes the parallel receive words of the output register.
  Assumes words are timed by clk and marked by one-cycle rxOutValid.
*/
`timescale 1ns/10ps
module roceb_host_model
  import roceb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire roceb_rxword_s rxOutWord,
  input wire logic rxOutValid,
  output roceb_rxword_s lastWord,
  output int wordCnt
);
  // take each word on the reference edge after it was loaded, no back-pressure exists
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wordCnt <= 0;
    end else if (rxOutValid) begin
      lastWord <= rxOutWord;
      wordCnt <= wordCnt + 1;
    end
  end
endmodule

// File: verification/testbench.sv
/*
  Self-checking bench of the receive output block: AXI4-Lite register tasks,
  character injection and output checks. Assumes the designer's register map.
*/
`timescale 1ns/10ps
module testbench;
  import roceb_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [9:0] rxCharIn = 10'h000;
  logic rxCharValid = 1'b0;
  roceb_rxword_s rxOutWord, lastWord;
  logic rxOutValid, rxOutClk, rxOutClkCopy, txRefCapture;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, c;
  logic [1:0] bresp, rresp, r;
  int wordCnt, w0;
  int error_cnt = 0;
  int checks = 0;
  logic [31:0] rangeExp [3] = '{32'h019000C3, 32'h03200190, 32'h05DC0320};

  always #12.5 clk = ~clk;

  // characters never outrun the reference clock here, so the high mark sits at half
  roceb_top #(.HI_TH(8)) i_roceb_top (.clk(clk), .nrst(nrst), .rxCharIn(rxCharIn),
    .rxCharValid(rxCharValid), .rxOutWord(rxOutWord), .rxOutValid(rxOutValid),
    .rxOutClk(rxOutClk), .rxOutClkCopy(rxOutClkCopy), .txRefCapture(txRefCapture),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  roceb_host_model i_roceb_host_model (.clk(clk), .nrst(nrst), .rxOutWord(rxOutWord),
    .rxOutValid(rxOutValid), .lastWord(lastWord), .wordCnt(wordCnt));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // each channel released at its own take, no latency assumed
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // one character, then let the one-cycle output path and the host settle
  task automatic send(input logic [9:0] ch);
    @(posedge clk);
    rxCharIn <= ch;
    rxCharValid <= 1'b1;
    @(posedge clk);
    rxCharValid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog: the sequence needs about 200 cycles, allow a hundred times that
  initial begin
    #500000;
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    check(rxOutValid, 0);
    check(rxOutWord, {10'h000, RXST_FILL});
    axi_rd(4'h0, d, r);
    check(d, 32'h00001555);
    axi_rd(4'h2, d, r);
    check(r, 2'b10);
    // every serial rate range; tx rate stays MID so no invalid pairing arises
    for (int s = 0; s < 3; s++) begin
      axi_wr(4'h0, 32'h00001515 | (s << 6), r);
      axi_rd(4'hC, d, r);
      check(d, rangeExp[s]);
    end
    axi_wr(4'h0, 32'h00001155, r);
    check(r, 2'b00);
    repeat (2) @(posedge clk);
    #1;
    check(txRefCapture, 1);
    axi_wr(4'h0, 32'h00001554, r);
    send(10'h2A5);
    check(lastWord, {10'h2A5, RXST_RAW});
    axi_wr(4'h0, 32'h00001555, r);
    send(10'h0FA);
    check(lastWord, {10'h0BC, RXST_COMMA});
    axi_wr(4'h0, 32'h00001556, r);
    send(10'h305);
    check(lastWord, {10'h0BC, RXST_SPECIAL});
    send(10'h2AA);
    check(lastWord, {10'h0B5, RXST_DATA});
    send(10'h000);
    check(lastWord, {10'h000, RXST_ERROR});
    // recovered clock: rate LOW toggles per character, rate MID per second one
    axi_wr(4'h0, 32'h00001545, r);
    #1;
    c = rxOutClk;
    send(10'h0FA);
    check(rxOutClk, !c);
    axi_wr(4'h0, 32'h00001555, r);
    #1;
    c = rxOutClk;
    send(10'h0FA);
    send(10'h0FA);
    check(rxOutClk, !c);
    // buffer mode after a fresh reset so the pointers start at nominal offset
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    // a full-rate framing stream meets the high mark once, at the nominal offset
    rxCharIn <= 10'h0FA;
    rxCharValid <= 1'b1;
    axi_wr(4'h0, 32'h00001551, r);
    #1;
    c = rxOutClk;
    @(posedge clk);
    #1;
    check(rxOutClk, !c);
    check(rxOutClkCopy, !c);
    w0 = wordCnt;
    // half-rate framing characters drain the buffer below its low mark
    for (int i = 0; i < 30; i++) begin
      @(posedge clk);
      rxCharIn <= 10'h0FA;
      rxCharValid <= 1'b1;
      @(posedge clk);
      rxCharValid <= 1'b0;
    end
    #1;
    check(wordCnt - w0 >= 55, 1);
    axi_rd(4'h4, d, r);
    check(d[0], 1);
    axi_rd(4'h8, d, r);
    check(d[15:0] != 16'h0000, 1);
    check(d[31:16], 16'h0001);
    close_out();
  end
endmodule
